/* File: core/cacsr_params.svh */
// Offsets, field positions, reset values and timing counts of the control block
`ifndef CACSR_PARAMS_SVH
`define CACSR_PARAMS_SVH

`define CACSR_ADDR_UPDATE     10'h000
`define CACSR_ADDR_STANDBY    10'h001
`define CACSR_ADDR_FE_LAST    10'h01f
`define CACSR_ADDR_CLAMP_LVL  10'h004
`define CACSR_ADDR_RUN_WATCH  10'h020
`define CACSR_ADDR_SEQ_FIRST  10'h037
`define CACSR_ADDR_SEQ_LAST   10'h0ff

`define CACSR_UPD_FE_SYNC     0
`define CACSR_UPD_POL_LO      1
`define CACSR_UPD_POL_HI      2
`define CACSR_UPD_SEQ_LINE    3
`define CACSR_STBY_FRONT      0
`define CACSR_STBY_CONV1      1
`define CACSR_STBY_CONV2      2
`define CACSR_RUN_SEQ         0
`define CACSR_RUN_WATCH       4

`define CACSR_RST_UPDATE      6'h00
`define CACSR_RST_STANDBY     6'h06
`define CACSR_RST_CLAMP_LVL   6'h08
`define CACSR_RST_RUN_WATCH   6'h10

`define CACSR_FRAME_BITS      5'h10
`define CACSR_LVL10_BASE      7'h10
`define CACSR_LVL12_BASE      9'h040
`define CACSR_BLACK_SKIP      3'h6

`define CACSR_CLK_PS          5000
`define CACSR_STOP_NS         1000
`define CACSR_STOP_CYC        ((`CACSR_STOP_NS * 1000) / `CACSR_CLK_PS)

`endif

/* File: core/cacsr_pkg.sv */
// Types of the front-end control block
package cacsr_pkg;

  typedef struct packed {
    logic       mck_s1;
    logic       mck_s2;
    logic       mck_s3;
    logic       sck_s1;
    logic       sck_s2;
    logic       sck_s3;
    logic       cs_s1;
    logic       cs_s2;
    logic       cs_s3;
    logic       sd_s1;
    logic       sd_s2;
    logic       ld_s1;
    logic       ld_s2;
    logic       ld_s3;
    logic       vs_s1;
    logic       vs_s2;
    logic       vs_s3;
    logic [15:0] sh;
    logic [4:0] bitcnt;
    logic [5:0] upd;
    logic [5:0] stby;
    logic [5:0] stby_p;
    logic       stby_pv;
    logic [5:0] lvl;
    logic [5:0] lvl_p;
    logic       lvl_pv;
    logic [5:0] run;
    logic       seq_pend;
    logic [7:0] stopcnt;
    logic       stopped;
    logic [2:0] bcnt;
    logic       o_ref;
    logic       o_data;
    logic       o_dum;
    logic       o_blk;
    logic       o_iclamp;
    logic       o_bcal;
    logic       o_oe;
    logic       o_c1;
    logic       o_c2;
    logic       o_trun;
    logic       o_seqap;
    logic [6:0] o_l10;
    logic [8:0] o_l12;
    logic       o_stop;
  } cacsr_st_t;

endpackage : cacsr_pkg

/* File: core/cacsr_core.sv */
// Common control: update timing, clock stop watch, standby, strobe gating, clamp level
//
// Behaviour
// - Sequencer settings apply now or at line
// - Polarity field picks load or sync edge
// - Bit 0 picks real-time or edge update
// - Register ranges follow their update selection
// - Clock stop watch enabled by generator_run_and_clock_watch[4]
// - Clock stop clears registers until chip reset
// - Sequencer standby while generator_run_and_clock_watch[0] is zero
// - Front standby floats its data outputs
// - Standby disables blocks, three independent controls
// - Late front standby after sequencer standby ignored when front updates wait for a vertical sync edge
// - Chip reset restores all defaults asynchronously
// - Sampler strobes are active low
// - Input clamp needs dummy and reference strobes
// - First six black window pixels not effective
`include "cacsr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cacsr_core (
  input  wire logic       CLK,
  input  wire logic       ARST_N,
  input  wire logic       CE,
  input  wire logic       PIXEL_MASTER_CLOCK,
  input  wire logic       SCLK,
  input  wire logic       SDATA,
  input  wire logic       CS_N,
  input  wire logic       LOAD_STROBE,
  input  wire logic       VERTICAL_SYNC,
  input  wire logic       VSEQ_LINE_HIT,
  input  wire logic       REF_SAMPLE_STROBE_N,
  input  wire logic       DATA_SAMPLE_STROBE_N,
  input  wire logic       DUMMY_CLAMP_STROBE_N,
  input  wire logic       BLACK_CLAMP_STROBE_N,
  output logic            SAMPLER_REF_N,
  output logic            SAMPLER_DATA_N,
  output logic            SAMPLER_DUMMY_N,
  output logic            SAMPLER_BLACK_N,
  output logic            INPUT_CLAMP_EN,
  output logic            BLACK_CAL_EN,
  output logic            FRONT_DATA_OE,
  output logic            CONV1_RUN,
  output logic            CONV2_RUN,
  output logic            SEQ_RUN,
  output logic            SEQ_SETTINGS_APPLY,
  output logic [6:0]      CLAMP_LEVEL_10,
  output logic [8:0]      CLAMP_LEVEL_12,
  output logic            MCK_STOPPED
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0]              rs_r;
  logic                    rst_n;
  cacsr_pkg::cacsr_st_t    st_r;
  cacsr_pkg::cacsr_st_t    st_nxt;

  localparam cacsr_pkg::cacsr_st_t ST_RST = '{
    sck_s1: 1'b1, sck_s2: 1'b1, sck_s3: 1'b1,
    cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1,
    upd: `CACSR_RST_UPDATE, stby: `CACSR_RST_STANDBY, stby_p: `CACSR_RST_STANDBY,
    lvl: `CACSR_RST_CLAMP_LVL, lvl_p: `CACSR_RST_CLAMP_LVL, run: `CACSR_RST_RUN_WATCH,
    o_ref: 1'b1, o_data: 1'b1, o_dum: 1'b1, o_blk: 1'b1,
    o_l10: 7'h20, o_l12: 9'h080,
    default: '0};

  localparam logic [7:0] STOP_CYC = 8'(`CACSR_STOP_CYC);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rs_r <= 2'h0;
    end else begin
      rs_r <= {rs_r[0], 1'b1};
    end
  end
  assign rst_n = rs_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  logic       sck_rise;
  logic       cs_rise;
  logic       ld_rise;
  logic       ld_fall;
  logic       vs_rise;
  logic       vs_fall;
  logic       mck_edge;
  logic       mck_rise;
  logic       fe_evt;
  logic       vs_mode;
  logic       wr;
  logic       front_off;
  logic [9:0] waddr;
  logic [5:0] wdata;
  logic [5:0] keep;

  always_comb begin
    st_nxt   = st_r;
    sck_rise = st_r.sck_s2 & ~st_r.sck_s3;
    cs_rise  = st_r.cs_s2 & ~st_r.cs_s3;
    ld_rise  = st_r.ld_s2 & ~st_r.ld_s3;
    ld_fall  = ~st_r.ld_s2 & st_r.ld_s3;
    vs_rise  = st_r.vs_s2 & ~st_r.vs_s3;
    vs_fall  = ~st_r.vs_s2 & st_r.vs_s3;
    mck_edge = st_r.mck_s2 ^ st_r.mck_s3;
    mck_rise = st_r.mck_s2 & ~st_r.mck_s3;
    waddr    = st_r.sh[9:0];
    wdata    = st_r.sh[15:10];

    // Pin synchronisers
    st_nxt.mck_s1 = PIXEL_MASTER_CLOCK;
    st_nxt.mck_s2 = st_r.mck_s1;
    st_nxt.mck_s3 = st_r.mck_s2;
    st_nxt.sck_s1 = SCLK;
    st_nxt.sck_s2 = st_r.sck_s1;
    st_nxt.sck_s3 = st_r.sck_s2;
    st_nxt.cs_s1  = CS_N;
    st_nxt.cs_s2  = st_r.cs_s1;
    st_nxt.cs_s3  = st_r.cs_s2;
    st_nxt.sd_s1  = SDATA;
    st_nxt.sd_s2  = st_r.sd_s1;
    st_nxt.ld_s1  = LOAD_STROBE;
    st_nxt.ld_s2  = st_r.ld_s1;
    st_nxt.ld_s3  = st_r.ld_s2;
    st_nxt.vs_s1  = VERTICAL_SYNC;
    st_nxt.vs_s2  = st_r.vs_s1;
    st_nxt.vs_s3  = st_r.vs_s2;

    // Standard write only, LSB first; longer streams keep the first frame
    if (!st_r.cs_s2 && sck_rise && st_r.bitcnt != `CACSR_FRAME_BITS) begin
      st_nxt.sh     = {st_r.sd_s2, st_r.sh[15:1]};
      st_nxt.bitcnt = st_r.bitcnt + 5'h01;
    end
    wr = cs_rise && st_r.bitcnt == `CACSR_FRAME_BITS && !st_r.stopped;
    if (cs_rise) begin
      st_nxt.bitcnt = 5'h00;
    end

    case (st_r.upd[`CACSR_UPD_POL_HI:`CACSR_UPD_POL_LO])
      2'h0:    fe_evt = ld_rise;
      2'h1:    fe_evt = ld_fall;
      2'h2:    fe_evt = vs_rise;
      2'h3:    fe_evt = vs_fall;
      default: fe_evt = 1'b0;
    endcase
    vs_mode = st_r.upd[`CACSR_UPD_FE_SYNC] & st_r.upd[`CACSR_UPD_POL_HI];

    // in vertical sync edge update mode, block new standby bits once sequencer sleeps
    keep = (vs_mode && !st_r.run[`CACSR_RUN_SEQ]) ? st_r.stby : 6'h3f;

    // apply held front values on edge
    if (st_r.upd[`CACSR_UPD_FE_SYNC] && fe_evt) begin
      if (st_r.stby_pv) begin
        st_nxt.stby    = st_r.stby_p & keep;
        st_nxt.stby_pv = 1'b0;
      end
      if (st_r.lvl_pv) begin
        st_nxt.lvl    = st_r.lvl_p;
        st_nxt.lvl_pv = 1'b0;
      end
    end

    st_nxt.o_seqap = 1'b0;
    if (st_r.seq_pend && VSEQ_LINE_HIT) begin
      st_nxt.o_seqap  = 1'b1;
      st_nxt.seq_pend = 1'b0;
    end

    if (wr) begin
      if (waddr == `CACSR_ADDR_UPDATE) begin
        st_nxt.upd = wdata;
      end else if (waddr == `CACSR_ADDR_RUN_WATCH) begin
        st_nxt.run = wdata;
      end else if (waddr == `CACSR_ADDR_STANDBY || waddr == `CACSR_ADDR_CLAMP_LVL) begin
        if (!st_r.upd[`CACSR_UPD_FE_SYNC]) begin
          if (waddr == `CACSR_ADDR_STANDBY) st_nxt.stby = wdata;
          else st_nxt.lvl = wdata;
        end else if (waddr == `CACSR_ADDR_STANDBY) begin
          st_nxt.stby_p  = wdata;
          st_nxt.stby_pv = 1'b1;
        end else begin
          st_nxt.lvl_p  = wdata;
          st_nxt.lvl_pv = 1'b1;
        end
      end else if (waddr >= `CACSR_ADDR_SEQ_FIRST && waddr <= `CACSR_ADDR_SEQ_LAST) begin
        if (st_r.upd[`CACSR_UPD_SEQ_LINE]) begin
          st_nxt.seq_pend = 1'b1;
        end else begin
          st_nxt.o_seqap = 1'b1;
        end
      end
    end

    // count reference cycles without clock edge
    if (mck_edge || !st_r.run[`CACSR_RUN_WATCH]) begin
      st_nxt.stopcnt = 8'h00;
    end else if (st_r.stopcnt != STOP_CYC) begin
      st_nxt.stopcnt = st_r.stopcnt + 8'h01;
    end
    if (st_r.run[`CACSR_RUN_WATCH] && st_r.stopcnt == STOP_CYC) begin
      st_nxt.stopped = 1'b1;
    end
    // stop clears all, held until reset
    if (st_r.stopped) begin
      st_nxt.upd      = 6'h00;
      st_nxt.stby     = 6'h00;
      st_nxt.stby_p   = 6'h00;
      st_nxt.stby_pv  = 1'b0;
      st_nxt.lvl      = 6'h00;
      st_nxt.lvl_p    = 6'h00;
      st_nxt.lvl_pv   = 1'b0;
      st_nxt.run      = 6'h00;
      st_nxt.seq_pend = 1'b0;
    end
    st_nxt.o_stop = st_r.stopped;

    front_off = st_r.stby[`CACSR_STBY_FRONT] | ~st_r.run[`CACSR_RUN_SEQ] | st_r.stopped;
    // sequencer runs only when bit set
    st_nxt.o_trun = st_r.run[`CACSR_RUN_SEQ] & ~st_r.stopped;
    // data outputs floated in front standby
    st_nxt.o_oe   = ~st_r.stby[`CACSR_STBY_FRONT] & ~st_r.stopped;
    st_nxt.o_c1   = ~st_r.stby[`CACSR_STBY_CONV1] & ~st_r.stopped;
    st_nxt.o_c2   = ~st_r.stby[`CACSR_STBY_CONV2] & ~st_r.stopped;

    // active-low strobes, masked high when idle
    st_nxt.o_ref  = REF_SAMPLE_STROBE_N | front_off;
    st_nxt.o_data = DATA_SAMPLE_STROBE_N | front_off;
    st_nxt.o_dum  = DUMMY_CLAMP_STROBE_N | front_off;
    st_nxt.o_blk  = BLACK_CLAMP_STROBE_N | front_off;
    st_nxt.o_iclamp = ~front_off & ~DUMMY_CLAMP_STROBE_N & ~REF_SAMPLE_STROBE_N;

    // skip first pixels of black window
    if (BLACK_CLAMP_STROBE_N || front_off) begin
      st_nxt.bcnt = 3'h0;
    end else if (mck_rise && st_r.bcnt != `CACSR_BLACK_SKIP) begin
      st_nxt.bcnt = st_r.bcnt + 3'h1;
    end
    st_nxt.o_bcal = ~BLACK_CLAMP_STROBE_N & ~front_off & (st_r.bcnt == `CACSR_BLACK_SKIP);

    st_nxt.o_l10 = `CACSR_LVL10_BASE + {1'b0, st_r.lvl[4:0], 1'b0};
    st_nxt.o_l12 = `CACSR_LVL12_BASE + {1'b0, st_r.lvl[4:0], 3'h0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  // async clear to defaults
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_RST;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign SAMPLER_REF_N      = st_r.o_ref;
  assign SAMPLER_DATA_N     = st_r.o_data;
  assign SAMPLER_DUMMY_N    = st_r.o_dum;
  assign SAMPLER_BLACK_N    = st_r.o_blk;
  assign INPUT_CLAMP_EN     = st_r.o_iclamp;
  assign BLACK_CAL_EN       = st_r.o_bcal;
  assign FRONT_DATA_OE      = st_r.o_oe;
  assign CONV1_RUN          = st_r.o_c1;
  assign CONV2_RUN          = st_r.o_c2;
  assign SEQ_RUN            = st_r.o_trun;
  assign SEQ_SETTINGS_APPLY = st_r.o_seqap;
  assign CLAMP_LEVEL_10     = st_r.o_l10;
  assign CLAMP_LEVEL_12     = st_r.o_l12;
  assign MCK_STOPPED        = st_r.o_stop;

endmodule : cacsr_core

`default_nettype wire

/* File: verif/cacsr_core_asserts.sv */
// Port checks for the control block
`timescale 1ns/1ps
`default_nettype none
module cacsr_asserts (
  input wire logic       CLK,
  input wire logic       ARST_N,
  input wire logic       CE,
  input wire logic       PIXEL_MASTER_CLOCK,
  input wire logic       REF_SAMPLE_STROBE_N,
  input wire logic       DUMMY_CLAMP_STROBE_N,
  input wire logic       BLACK_CLAMP_STROBE_N,
  input wire logic       SAMPLER_REF_N,
  input wire logic       SAMPLER_DUMMY_N,
  input wire logic       SAMPLER_BLACK_N,
  input wire logic       INPUT_CLAMP_EN,
  input wire logic       BLACK_CAL_EN,
  input wire logic       FRONT_DATA_OE,
  input wire logic       SEQ_RUN,
  input wire logic       SEQ_SETTINGS_APPLY,
  input wire logic [6:0] CLAMP_LEVEL_10,
  input wire logic [8:0] CLAMP_LEVEL_12,
  input wire logic       MCK_STOPPED
);
  logic [7:0] idle_r;
  logic       pin_r;
  logic       on;
  assign on = FRONT_DATA_OE && SEQ_RUN;
  // Saturates, so a long stop never wraps to zero
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      idle_r <= 8'h00;
      pin_r  <= 1'b0;
    end else begin
      pin_r  <= PIXEL_MASTER_CLOCK;
      idle_r <= (pin_r != PIXEL_MASTER_CLOCK) ? 8'h00 : idle_r + 8'(idle_r != 8'hff);
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_window;
    $fell(BLACK_CLAMP_STROBE_N) && on;
  endsequence
  a_strobe_copy: assert property (on && $past(on) && $past(CE) |->
    {SAMPLER_REF_N, SAMPLER_DUMMY_N, SAMPLER_BLACK_N} ==
    $past({REF_SAMPLE_STROBE_N, DUMMY_CLAMP_STROBE_N, BLACK_CLAMP_STROBE_N})) else $error("strobe copy wrong");
  a_clamp_gate: assert property (on && $past(on) && $past(CE) |->
    INPUT_CLAMP_EN == $past(!DUMMY_CLAMP_STROBE_N && !REF_SAMPLE_STROBE_N)) else $error("clamp gate wrong");
  a_level_map: assert property (CLAMP_LEVEL_12 == {CLAMP_LEVEL_10, 2'b00} &&
    !CLAMP_LEVEL_10[0] && CLAMP_LEVEL_10 >= 7'h10) else $error("clamp levels disagree");
  a_apply_pulse: assert property (SEQ_SETTINGS_APPLY |=> !SEQ_SETTINGS_APPLY)
    else $error("apply longer than one cycle");
  a_stop_sticky: assert property (MCK_STOPPED |=> MCK_STOPPED)
    else $error("stop flag dropped");
  a_stop_clears: assert property ($past(MCK_STOPPED, 2) |->
    !SEQ_RUN && !FRONT_DATA_OE && CLAMP_LEVEL_10 == 7'h10) else $error("stop left state");
  a_stop_wait: assert property ($rose(MCK_STOPPED) |-> idle_r >= 8'd190)
    else $error("stop flagged too early");
  a_black_skip: assert property (s_window |=> !BLACK_CAL_EN [*8])
    else $error("calibration too early");
endmodule : cacsr_asserts
`default_nettype wire

/* File: verif/cacsr_host.sv */
// Serial host model sending register frames
`timescale 1ns/1ps
`default_nettype none
module cacsr_host (
  input  wire logic clk,
  output var logic  sclk,
  output var logic  sdata,
  output var logic  cs_n
);
  initial begin
    sclk  = 1'b0;
    sdata = 1'b0;
    cs_n  = 1'b1;
  end
  task automatic write(input logic [9:0] addr, input logic [5:0] data);
    logic [15:0] f;
    f = {data, addr};
    @(posedge clk) #1 cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      sdata = f[i];
      repeat (4) @(posedge clk);
      #1 sclk = 1'b1;
      repeat (4) @(posedge clk);
      #1 sclk = 1'b0;
    end
    repeat (4) @(posedge clk);
    #1 cs_n = 1'b1;
    // Released line flips so a stale bit cannot pass
    sdata = ~sdata;
    repeat (8) @(posedge clk);
    #1;
  endtask : write
endmodule : cacsr_host
`default_nettype wire

/* File: verif/ccd_afe_control_standby_reset_test.sv */
// Self-checking bench for the control block
`timescale 1ns/1ps
`default_nettype none
module ccd_afe_control_standby_reset_test;
  logic       clk = 1'b0, arst_n = 1'b0, pclk = 1'b0, pclk_on = 1'b1, load = 1'b0, vsync = 1'b0, hit = 1'b0;
  logic       ce = 1'b1;
  logic [3:0] stb = 4'hf;
  logic [3:0] prev;
  wire  [3:0] smp;
  logic       sclk, sdata, cs_n, iclamp, bcal, oe, c1, c2, srun, apply, stopped;
  logic [6:0] l10;
  logic [8:0] l12;
  int         n_errors = 0, num_checks = 0, cyc = 0, npulse = 0, code = 8;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (apply === 1'b1) npulse <= npulse + 1;
    if (pclk_on && cyc[0]) pclk <= #1 ~pclk;
    if (cyc == 30000) begin
      n_errors = n_errors + 1;
      report_and_stop();
    end
  end
  cacsr_host u_cacsr_host (.clk(clk), .sclk(sclk), .sdata(sdata), .cs_n(cs_n));
  cacsr_core u_cacsr_core (.CLK(clk), .ARST_N(arst_n), .CE(ce), .PIXEL_MASTER_CLOCK(pclk),
    .SCLK(sclk), .SDATA(sdata), .CS_N(cs_n), .LOAD_STROBE(load), .VERTICAL_SYNC(vsync), .VSEQ_LINE_HIT(hit),
    .REF_SAMPLE_STROBE_N(stb[3]), .DATA_SAMPLE_STROBE_N(stb[2]), .DUMMY_CLAMP_STROBE_N(stb[1]),
    .BLACK_CLAMP_STROBE_N(stb[0]), .SAMPLER_REF_N(smp[3]), .SAMPLER_DATA_N(smp[2]), .SAMPLER_DUMMY_N(smp[1]),
    .SAMPLER_BLACK_N(smp[0]), .INPUT_CLAMP_EN(iclamp), .BLACK_CAL_EN(bcal), .FRONT_DATA_OE(oe), .CONV1_RUN(c1),
    .CONV2_RUN(c2), .SEQ_RUN(srun), .SEQ_SETTINGS_APPLY(apply), .CLAMP_LEVEL_10(l10), .CLAMP_LEVEL_12(l12),
    .MCK_STOPPED(stopped));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input int d);
    u_cacsr_host.write(a, 6'(d));
  endtask : wr
  task automatic levels(input int c);
    chk({2'b00, l10}, 9'(16 + 2 * c));
    chk(l12, 9'(64 + 8 * c));
  endtask : levels
  task automatic defaults;
    levels(8);
    chk({4'h0, oe, c1, c2, srun, stopped}, 9'h010);
  endtask : defaults
  task automatic do_reset;
    arst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
  endtask : do_reset
  task automatic report_and_stop;
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////
  initial begin
    void'($urandom(18820));
    do_reset();
    defaults();
    for (int v = 0; v < 8; v++) begin
      wr(10'h001, v);
      chk({6'h00, oe, c1, c2}, {6'h00, !v[0], !v[1], !v[2]});
    end
    wr(10'h001, 0);
    repeat (3) begin
      code = $urandom % 32;
      wr(10'h004, code);
      levels(code);
    end
    for (int p = 0; p < 4; p++) begin
      load = (p == 1);
      vsync = (p == 3);
      wr(10'h000, 2 * p + 1);
      wr(10'h004, p + 20);
      levels(code);
      if (p < 2) load = !load;
      else vsync = !vsync;
      repeat (8) @(posedge clk);
      #1 code = p + 20;
      levels(code);
    end
    wr(10'h001, 7);
    vsync = 1'b1;
    repeat (8) @(posedge clk);
    #1 vsync = 1'b0;
    repeat (8) @(posedge clk);
    #1 chk({6'h00, oe, c1, c2}, 9'h007);
    wr(10'h000, 0);
    wr(10'h020, 6'h11);
    chk({8'h00, srun}, 9'h001);
    wr(10'h037, 6'h15);
    chk(9'(npulse), 9'h001);
    wr(10'h000, 6'h08);
    wr(10'h037, 6'h2a);
    chk(9'(npulse), 9'h001);
    hit = 1'b1;
    @(posedge clk) #1 hit = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(9'(npulse), 9'h002);
    wr(10'h000, 0);
    prev = stb;
    repeat (40) begin
      @(posedge clk) #1 chk({4'h0, iclamp, smp}, {4'h0, !prev[3] && !prev[1], prev});
      stb = 4'($urandom);
      prev = stb;
    end
    @(posedge clk) #1 ce = 1'b0;
    stb = 4'he;
    repeat (20) @(posedge clk);
    #1 chk({4'h0, iclamp, smp}, {4'h0, !prev[3] && !prev[1], prev});
    ce = 1'b1;
    repeat (60) @(posedge clk);
    #1 chk({8'h00, bcal}, 9'h001);
    stb = 4'h0;
    wr(10'h001, 1);
    chk({4'h0, iclamp, smp}, 9'h00f);
    wr(10'h020, 6'h01);
    pclk_on = 1'b0;
    repeat (300) @(posedge clk);
    #1 chk({8'h00, stopped}, 9'h000);
    pclk_on = 1'b1;
    wr(10'h020, 6'h11);
    pclk_on = 1'b0;
    repeat (300) @(posedge clk);
    #1 wr(10'h004, 6'h1f);
    levels(0);
    chk({6'h00, stopped, srun, oe}, 9'h004);
    pclk_on = 1'b1;
    do_reset();
    defaults();
    report_and_stop();
  end
endmodule : ccd_afe_control_standby_reset_test
bind cacsr_core cacsr_asserts u_cacsr_asserts (.CLK(CLK), .ARST_N(ARST_N), .PIXEL_MASTER_CLOCK(PIXEL_MASTER_CLOCK),
  .CE(CE), .REF_SAMPLE_STROBE_N(REF_SAMPLE_STROBE_N), .DUMMY_CLAMP_STROBE_N(DUMMY_CLAMP_STROBE_N),
  .BLACK_CLAMP_STROBE_N(BLACK_CLAMP_STROBE_N), .SAMPLER_REF_N(SAMPLER_REF_N), .SAMPLER_DUMMY_N(SAMPLER_DUMMY_N),
  .SAMPLER_BLACK_N(SAMPLER_BLACK_N), .INPUT_CLAMP_EN(INPUT_CLAMP_EN), .BLACK_CAL_EN(BLACK_CAL_EN),
  .FRONT_DATA_OE(FRONT_DATA_OE), .SEQ_RUN(SEQ_RUN), .SEQ_SETTINGS_APPLY(SEQ_SETTINGS_APPLY),
  .CLAMP_LEVEL_10(CLAMP_LEVEL_10), .CLAMP_LEVEL_12(CLAMP_LEVEL_12), .MCK_STOPPED(MCK_STOPPED));
`default_nettype wire
